/* design/eew_pkg.sv */
package eew_pkg;

    // ************************************************************
    // clock and device timing
    // ************************************************************
    localparam int CLK_NS = 5;

    // least times round up to whole cycles
    function automatic int nsToCyc(input int ns);
        return (ns + CLK_NS - 1) / CLK_NS;
    endfunction

    localparam int T_WP_NS    = 100;   // write strobe low
    localparam int T_WPH_NS   = 50;    // write strobe high
    localparam int T_ACC_NS   = 120;   // slowest read access
    localparam int T_OEHP_NS  = 150;   // strobe high between polls
    localparam int T_BLC_US   = 150;   // byte load window, longest
    localparam int TWC_STD_MS = 10;
    localparam int TWC_FAST_MS = 3;

    localparam logic [5:0] WP_CYC   = 6'(nsToCyc(T_WP_NS));
    localparam logic [5:0] WPH_CYC  = 6'(nsToCyc(T_WPH_NS));
    localparam logic [5:0] ACC_CYC  = 6'(nsToCyc(T_ACC_NS));
    localparam logic [5:0] OEHP_CYC = 6'(nsToCyc(T_OEHP_NS));
    localparam int BLC_CYC      = T_BLC_US * 1000 / CLK_NS;
    localparam int TWC_STD_CYC  = TWC_STD_MS * 1000000 / CLK_NS;
    localparam int TWC_FAST_CYC = TWC_FAST_MS * 1000000 / CLK_NS;
    localparam int TWC_W        = 22;

    // ************************************************************
    // device geometry
    // ************************************************************
    localparam int ADDR_W     = 15;
    localparam int DATA_W     = 8;
    localparam int PAGE_LSB   = 6;     // page_address_low_bit
    localparam int PAGE_N     = 64;
    localparam int SEQ_N      = 6;
    localparam int TOGGLE_BIT = 6;     // toggle_status_bit

    // ************************************************************
    // register map and fields
    // ************************************************************
    localparam int APB_AW = 12;
    localparam logic [11:0] REG_CTRL    = 12'h000;
    localparam logic [11:0] REG_STAT    = 12'h004;
    localparam logic [11:0] REG_ADDR    = 12'h008;
    localparam logic [11:0] REG_SEQ     = 12'h010;
    localparam logic [11:0] REG_SEQ_END = REG_SEQ + 12'(4 * SEQ_N);
    localparam logic [11:0] REG_BUF     = 12'h100;

    localparam int CTRL_GO   = 0;
    localparam int CTRL_OP   = 1;
    localparam int CTRL_FAST = 3;
    localparam int CTRL_SEL  = 4;
    localparam int CTRL_CNT  = 6;
    localparam int CTRL_SEQ  = 12;
    localparam int STAT_DONE = 1;
    localparam int STAT_ERR  = 2;

    typedef enum logic [1:0] {
        OP_READ  = 2'h0,
        OP_WRITE = 2'h1,
        OP_PROT  = 2'h2,
        OP_CODE  = 2'h3
    } eew_op_e;

    typedef enum logic [1:0] {
        SEL_BOTH = 2'h0,
        SEL_OE   = 2'h1,
        SEL_CE   = 2'h2,
        SEL_ALL  = 2'h3
    } eew_sel_e;

endpackage

/* design/eew_cyc_if.sv */
`timescale 1ns/100ps
interface eew_cyc_if;
    import eew_pkg::*;
    logic        req;
    logic        isWr;
    logic        hold;
    logic [14:0] addr;
    logic [7:0]  wdata;
    eew_sel_e    sel;
    logic        done;
    logic [7:0]  rdata;

    modport ctl (output req, isWr, hold, addr, wdata, sel, input done, rdata);
    modport eng (input req, isWr, hold, addr, wdata, sel, output done, rdata);
endinterface

/* design/eew_timer.sv */
`timescale 1ns/100ps
module eew_timer
    import eew_pkg::*;
#(
    parameter int W = TWC_W
) (
    input  wire logic         clk_sys,
    input  wire logic         arst_n,
    input  wire logic         start,
    input  wire logic [W-1:0] limit,
    output logic              expired
);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         run;
        logic         exp;
    } eew_tmr_s;

    eew_tmr_s st;
    eew_tmr_s n;

    // free count from start, expiry stays until the next start
    always_comb begin
        n = st;
        if (start) begin
            n.cnt = '0;
            n.run = 1'b1;
            n.exp = 1'b0;
        end else if (st.run) begin
            n.cnt = st.cnt + 1'b1;
            if (st.cnt == limit - 1'b1) begin
                n.run = 1'b0;
                n.exp = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= n;
        end
    end

    assign expired = st.exp;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    exp_at_limit_a: assert property ($rose(st.exp) |-> $past(st.cnt) == limit - 1'b1)
        else $error("timer expired early or late");

endmodule // eew_timer

/* design/eew_strobe.sv */
`timescale 1ns/100ps
module eew_strobe
    import eew_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    eew_cyc_if.eng           cyc,
    input  wire logic [7:0]  memDataIn,
    output logic [14:0]      memAddr,
    output logic             memCeN,
    output logic             memOeN,
    output logic             memWeN,
    output logic [7:0]       memDataOut,
    output logic             memDataOe
);

    typedef enum logic [1:0] {
        PH_IDLE  = 2'h0,
        PH_SETUP = 2'h1,
        PH_LOW   = 2'h2,
        PH_HIGH  = 2'h3
    } eew_ph_e;

    typedef struct packed {
        eew_ph_e     ph;
        logic [5:0]  cnt;
        logic        isWr;
        eew_sel_e    sel;
        logic [14:0] addr;
        logic [7:0]  dOut;
        logic        dOe;
        logic        ceN;
        logic        oeN;
        logic        weN;
        logic [7:0]  rdata;
        logic        done;
    } eew_eng_s;

    eew_eng_s st;
    eew_eng_s n;
    logic     act;
    logic     held;

    // ************************************************************
    // one pin cycle: setup, strobe low, strobe high
    // ************************************************************
    always_comb begin
        n = st;
        n.done = 1'b0;
        unique case (st.ph)
            PH_IDLE: if (cyc.req) begin
                n.ph   = PH_SETUP;
                n.isWr = cyc.isWr;
                n.sel  = cyc.sel;
                n.addr = cyc.addr;    // address_top_bit..address_bottom_bit
                n.dOut = cyc.wdata;   // polling_status_bit..data_line_low
            end
            PH_SETUP: begin
                n.ph  = PH_LOW;
                n.cnt = st.isWr ? WP_CYC - 6'h1 : ACC_CYC - 6'h1;
            end
            PH_LOW: if (st.cnt == 6'h0) begin
                n.ph    = PH_HIGH;
                n.cnt   = st.isWr ? WPH_CYC - 6'h1 : OEHP_CYC - 6'h1;
                n.rdata = memDataIn;  // sampled after full access time
            end else begin
                n.cnt = st.cnt - 6'h1;
            end
            PH_HIGH: if (st.cnt == 6'h0) begin
                n.ph   = PH_IDLE;
                n.done = 1'b1;
            end else begin
                n.cnt = st.cnt - 6'h1;
            end
        endcase
        // strobes follow the next phase so they leave a flop clean
        act  = n.ph == PH_LOW;
        held = n.ph != PH_IDLE || cyc.hold;
        if (n.isWr) begin
            n.weN = !act;
            n.ceN = !act;
            n.oeN = 1'b1;
        end else begin
            n.weN = 1'b1;
            n.oeN = !((n.sel != SEL_CE) ? act : held);
            n.ceN = !((n.sel != SEL_OE) ? act : held);
        end
        n.dOe = n.isWr && n.ph != PH_IDLE;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st     <= '0;
            st.ceN <= 1'b1;
            st.oeN <= 1'b1;
            st.weN <= 1'b1;
        end else begin
            st <= n;
        end
    end

    assign memAddr    = st.addr;
    assign memCeN     = st.ceN;
    assign memOeN     = st.oeN;
    assign memWeN     = st.weN;
    assign memDataOut = st.dOut;
    assign memDataOe  = st.dOe;
    assign cyc.done   = st.done;
    assign cyc.rdata  = st.rdata;

    // ************************************************************
    // checks
    // ************************************************************
    localparam int WP_N = WP_CYC;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    oe_high_a: assert property (!st.weN && !st.ceN |-> st.oeN)
        else $error("output enable low during write strobe");
    strobe_sel_a: assert property (st.ph == PH_HIGH && !st.isWr && st.sel == SEL_OE |-> !st.ceN && st.oeN)
        else $error("held chip select released in output enable mode");
    write_pulse_a: assert property ($fell(st.weN) |-> !st.dOe == 1'b0 ##WP_N $rose(st.weN))
        else $error("write strobe width wrong");

endmodule // eew_strobe

/* design/eew_ctrl.sv */
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/100ps
module eew_ctrl
    import eew_pkg::*;
#(
    parameter int TWC_STD  = TWC_STD_CYC,
    parameter int TWC_FAST = TWC_FAST_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic [14:0]      memAddr,
    output logic             memCeN,
    output logic             memOeN,
    output logic             memWeN,
    input  wire logic [7:0]  memDataIn,
    output logic [7:0]       memDataOut,
    output logic             memDataOe
);

    // ************************************************************
    // state
    // ************************************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_SEQ  = 3'h1,
        ST_DATA = 3'h2,
        ST_POLL = 3'h3,
        ST_READ = 3'h4
    } eew_fsm_e;

    typedef struct packed {
        eew_fsm_e                       fsm;
        eew_op_e                        op;
        logic                           fast;
        eew_sel_e                       sel;
        logic [5:0]                     cnt;
        logic [2:0]                     seqLen;
        logic [ADDR_W-1:0]              addr;
        logic [SEQ_N-1:0][22:0]         seq;
        logic [PAGE_N-1:0][DATA_W-1:0]  pbuf;
        logic [6:0]                     idx;
        logic [2:0]                     seqIdx;
        logic                           inFlight;
        logic                           req;
        logic                           curWr;
        logic [ADDR_W-1:0]              curAddr;
        logic [DATA_W-1:0]              curData;
        logic [ADDR_W-1:0]              pollAddr;
        logic                           prevBit;
        logic                           havePrev;
        logic                           tmrStart;
        logic                           done;
        logic                           err;
        logic [DATA_W-1:0]              rdByte;
        logic [15:0]                    gap;
        logic [31:0]                    prdata;
        logic                           pready;
        logic                           pslverr;
    } eew_top_s;

    eew_top_s          st;
    eew_top_s          n;
    logic              busy;
    logic              wrEn;
    logic              launch;
    logic              tmrExp;
    logic [TWC_W-1:0]  tmrLimit;
    logic [6:0]        lastIdx;

    eew_cyc_if cyc ();

    // ************************************************************
    // address decode helpers
    // ************************************************************
    function automatic logic seqHit(input logic [11:0] a);
        return a[1:0] == 2'h0 && a >= REG_SEQ && a < REG_SEQ_END;
    endfunction

    function automatic logic [2:0] seqIdxOf(input logic [11:0] a);
        return 3'((a - REG_SEQ) >> 2);
    endfunction

    function automatic logic bufHit(input logic [11:0] a);
        return a[11:8] == REG_BUF[11:8] && a[1:0] == 2'h0;
    endfunction

    function automatic logic mapped(input logic [11:0] a);
        return a == REG_CTRL || a == REG_STAT || a == REG_ADDR || seqHit(a) || bufHit(a);
    endfunction

    function automatic logic [31:0] rdWord(input logic [11:0] a);
        logic [31:0] w;
        w = 32'h0;
        if (a == REG_CTRL) begin
            w = {17'h0, st.seqLen, st.cnt, st.sel, st.fast, st.op, 1'b0};
        end else if (a == REG_STAT) begin
            w = {16'h0, st.rdByte, 5'h0, st.err, st.done, busy};
        end else if (a == REG_ADDR) begin
            w = {17'h0, st.addr};
        end else if (seqHit(a)) begin
            w = {9'h0, st.seq[seqIdxOf(a)]};
        end else if (bufHit(a)) begin
            w = {24'h0, st.pbuf[a[7:2]]};
        end
        return w;
    endfunction

    assign busy     = st.fsm != ST_IDLE;
    assign wrEn     = psel && penable && pwrite && st.pready;
    assign launch   = wrEn && paddr == REG_CTRL && pwdata[CTRL_GO] && !busy;
    assign tmrLimit = st.fast ? TWC_W'(TWC_FAST) : TWC_W'(TWC_STD);
    assign lastIdx  = {1'b0, st.cnt} + 7'h1;

    // ************************************************************
    // bus slave and command sequencer
    // ************************************************************
    always_comb begin
        n = st;
        n.req      = 1'b0;
        n.tmrStart = 1'b0;
        // zero wait states: answer prepared in the setup cycle
        n.pready  = psel && !penable;
        n.prdata  = 32'h0;
        n.pslverr = 1'b0;
        if (psel && !penable) begin
            n.prdata  = pwrite ? 32'h0 : rdWord(paddr);
            n.pslverr = !mapped(paddr);
        end
        // status clear first, so a same-cycle hardware set wins
        if (wrEn && paddr == REG_STAT) begin
            if (pwdata[STAT_DONE]) n.done = 1'b0;
            if (pwdata[STAT_ERR]) n.err = 1'b0;
        end
        // config is frozen while a command runs
        if (wrEn && !busy) begin
            if (paddr == REG_CTRL) begin
                n.op     = eew_op_e'(pwdata[CTRL_OP+:2]);
                n.fast   = pwdata[CTRL_FAST];
                n.sel    = eew_sel_e'(pwdata[CTRL_SEL+:2]);
                n.cnt    = pwdata[CTRL_CNT+:6];
                n.seqLen = pwdata[CTRL_SEQ+:3];
            end
            if (paddr == REG_ADDR) n.addr = pwdata[ADDR_W-1:0];
            if (seqHit(paddr)) n.seq[seqIdxOf(paddr)] = pwdata[22:0];
            if (bufHit(paddr)) n.pbuf[paddr[7:2]] = pwdata[DATA_W-1:0];
        end
        // time since the last byte ended, so a stalled engine trips the load window
        n.gap = (st.fsm == ST_DATA && !cyc.done) ? st.gap + 16'h1 : 16'h0;

        unique case (st.fsm)
            ST_IDLE: if (launch) begin
                n.idx      = 7'h0;
                n.seqIdx   = 3'h0;
                n.havePrev = 1'b0;
                unique case (eew_op_e'(pwdata[CTRL_OP+:2]))
                    OP_READ:  n.fsm = ST_READ;
                    OP_WRITE: n.fsm = ST_DATA;
                    OP_PROT:  n.fsm = ST_SEQ;
                    OP_CODE:  n.fsm = ST_SEQ;
                endcase
            end
            ST_SEQ: if (cyc.done) begin
                n.inFlight = 1'b0;
                n.seqIdx   = st.seqIdx + 3'h1;
            end else if (!st.inFlight) begin
                if (st.seqIdx >= st.seqLen) begin
                    // code alone still ends in a write period
                    n.fsm      = (st.op == OP_CODE) ? ST_POLL : ST_DATA;
                    n.tmrStart = st.op == OP_CODE;
                end else begin
                    n.req      = 1'b1;       // supplied command writes
                    n.inFlight = 1'b1;
                    n.curWr    = 1'b1;
                    n.curAddr  = st.seq[st.seqIdx][22:8];
                    n.curData  = st.seq[st.seqIdx][7:0];
                    n.pollAddr = st.seq[st.seqIdx][22:8];
                end
            end
            ST_DATA: if (cyc.done) begin
                n.inFlight = 1'b0;
                n.idx      = st.idx + 7'h1;
            end else if (!st.inFlight) begin
                if (st.idx == lastIdx) begin
                    n.fsm      = ST_POLL;   // all cnt+1 loaded bytes in one write
                    n.tmrStart = 1'b1;
                end else begin
                    // page bits held, only the byte offset moves
                    n.req      = 1'b1;
                    n.inFlight = 1'b1;
                    n.curWr    = 1'b1;
                    n.curAddr  = {st.addr[ADDR_W-1:PAGE_LSB], st.idx[PAGE_LSB-1:0]};
                    n.curData  = st.pbuf[st.idx[PAGE_LSB-1:0]];
                    n.pollAddr = n.curAddr;
                end
            end
            ST_POLL: if (cyc.done) begin
                n.inFlight = 1'b0;
                // equal successive bits mean the timer stopped
                if (st.havePrev && cyc.rdata[TOGGLE_BIT] == st.prevBit) begin
                    n.fsm    = ST_IDLE;
                    n.done   = 1'b1;
                    n.rdByte = cyc.rdata;
                end else begin
                    n.prevBit  = cyc.rdata[TOGGLE_BIT];
                    n.havePrev = 1'b1;
                end
            end else if (!st.inFlight) begin
                // expiry left over from the last command still stands in the start cycle
                if (tmrExp && !st.tmrStart) begin
                    n.fsm = ST_IDLE;   // no end seen in the longest write
                    n.err = 1'b1;
                end else begin
                    n.req      = 1'b1;
                    n.inFlight = 1'b1;
                    n.curWr    = 1'b0;
                    n.curAddr  = st.pollAddr;
                end
            end
            ST_READ: if (cyc.done) begin
                n.inFlight = 1'b0;
                n.fsm      = ST_IDLE;
                n.done     = 1'b1;
                n.rdByte   = cyc.rdata;
            end else if (!st.inFlight) begin
                n.req      = 1'b1;
                n.inFlight = 1'b1;
                n.curWr    = 1'b0;
                n.curAddr  = st.addr;
            end
            default: n.fsm = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= n;
        end
    end

    // ************************************************************
    // pin engine and write timer
    // ************************************************************
    assign cyc.req   = st.req;
    assign cyc.isWr  = st.curWr;
    assign cyc.hold  = st.fsm == ST_POLL;  // keeps the unpulsed strobe low
    assign cyc.addr  = st.curAddr;
    assign cyc.wdata = st.curData;
    assign cyc.sel   = st.sel;

    eew_strobe u_strobe (
        .clk_sys    (clk_sys),
        .arst_n     (arst_n),
        .cyc        (cyc.eng),
        .memDataIn  (memDataIn),
        .memAddr    (memAddr),
        .memCeN     (memCeN),
        .memOeN     (memOeN),
        .memWeN     (memWeN),
        .memDataOut (memDataOut),
        .memDataOe  (memDataOe)
    );

    eew_timer #(
        .W (TWC_W)
    ) u_tmr (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .start   (st.tmrStart),
        .limit   (tmrLimit),
        .expired (tmrExp)
    );

    assign prdata  = st.prdata;
    assign pready  = st.pready;
    assign pslverr = st.pslverr;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    page_stable_a: assert property (st.req && st.fsm == ST_DATA |-> st.curAddr[14:6] == st.addr[14:6])
        else $error("page bits moved during page load");
    count_range_a: assert property (st.fsm == ST_DATA ##1 st.fsm == ST_POLL |-> $past(st.idx) == lastIdx)
        else $error("byte count differs from programmed count");
    poll_addr_a: assert property (st.fsm == ST_POLL && $past(st.fsm) == ST_POLL |-> $stable(st.pollAddr))
        else $error("poll address changed inside one write cycle");
    poll_read_a: assert property (st.req && st.fsm == ST_POLL |-> st.curAddr == st.pollAddr && !st.curWr)
        else $error("poll read not at the held address");
    toggle_cmp_a: assert property ($rose(st.done) && $past(st.fsm) == ST_POLL |-> $past(st.havePrev))
        else $error("completion without two compared reads");
    seq_first_a: assert property (st.req && st.fsm == ST_DATA && st.op == OP_PROT |-> st.seqIdx >= st.seqLen)
        else $error("page data before command sequence ended");
    time_bound_a: assert property ($rose(st.err) |-> $past(tmrExp) && $past(st.fsm) == ST_POLL)
        else $error("write timeout flagged before limit");
    load_window_a: assert property (st.fsm == ST_DATA |-> st.gap < BLC_CYC)
        else $error("byte load gap too long");
    apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("bus answer not one cycle");

endmodule // eew_ctrl

/* verification/eew_dev_model.sv */
`timescale 1ns/100ps
module eew_dev_model
    import eew_pkg::*;
#(
    parameter int BUSY_NS = 4000   // between the bench's fast and standard limits
) (
    input  wire logic [14:0] memAddr,
    input  wire logic        memCeN,
    input  wire logic        memOeN,
    input  wire logic        memWeN,
    input  wire logic [7:0]  memDataOut,
    input  wire logic        memDataOe,
    output logic [7:0]       memDataIn
);
    // ****************************************
    // behavioural array with internal write timer
    // ****************************************
    logic [7:0] mem [0:32767];
    logic       busy = 1'b0;
    logic       tog  = 1'b0;
    time        doneAt = 0;
    wire        wrN = memCeN | memWeN;
    wire        rdN = memCeN | memOeN;

    // each loaded byte restarts the timer, so any count up to a page lands in one cycle
    // a byte only lands while the controller drives the data bus
    always @(posedge wrN) if (memOeN === 1'b1 && memDataOe === 1'b1) begin
        mem[memAddr] = memDataOut;
        busy = 1'b1;
        doneAt = $time + BUSY_NS;
    end
    // any strobe choice that selects a read flips the status bit while busy
    always @(negedge rdN) if (busy) tog = ~tog;
    // write period ends, busy clears and reads show the array again
    always #5 if (busy && $time >= doneAt) busy = 1'b0;
    // released bus shows the inverse of the last value, never a kind constant
    always @(rdN or busy or tog or memAddr) begin
        if (!rdN) memDataIn = busy ? {1'b0, tog, 6'h00} : mem[memAddr];
        else memDataIn = ~memDataIn;
    end
endmodule // eew_dev_model

/* verification/eeprom_write_protect_and_status_bench.sv */
`timescale 1ns/100ps
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin errTotal++; $display("Error %s exp %h got %h", nm, e, s); end end
module eeprom_write_protect_and_status_bench;
    import eew_pkg::*;
    // ****************************************
    // stimulus, design and device
    // ****************************************
    logic        clk_sys = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, slvErr, memCeN, memOeN, memWeN, memDataOe;
    logic [14:0] memAddr;
    logic [7:0]  memDataIn, memDataOut;
    int          errTotal = 0, compares = 0;

    always #2.5 clk_sys = ~clk_sys;
    eew_ctrl #(.TWC_STD(2000), .TWC_FAST(600)) eew_ctrl_i (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .memAddr(memAddr), .memCeN(memCeN), .memOeN(memOeN), .memWeN(memWeN),
        .memDataIn(memDataIn), .memDataOut(memDataOut), .memDataOe(memDataOe));
    eew_dev_model eew_dev_model_i (.memAddr(memAddr), .memCeN(memCeN), .memOeN(memOeN), .memWeN(memWeN),
        .memDataOut(memDataOut), .memDataOe(memDataOe), .memDataIn(memDataIn));

    // one apb transfer, request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1 && ++n < 100);
        if (pready !== 1'b1) errTotal++;
        rd = prdata;
        slvErr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // status polled by software; bounded so a stuck command cannot hang
    task automatic waitDone();
        int n;
        n = 0;
        rd = 32'h0;
        // ends on done or on the timeout error bit
        while (rd[STAT_ERR:STAT_DONE] == 2'b00 && n < 3000) begin apb(1'b0, REG_STAT, 32'h0); n++; end
        if (n == 3000) errTotal++;
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, errTotal);
        if (errTotal == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // ****************************************
    // tests
    // ****************************************
    initial begin
        repeat (3) @(posedge clk_sys);
        arst_n <= 1'b1;
        apb(1'b0, REG_STAT, 32'h0); `CHK("stat reset", 32'h0, rd)
        apb(1'b0, 12'h0f0, 32'h0); `CHK("unmapped slverr", 1'b1, slvErr)
        $display("test reset finished");
        // two-byte page write then readback, once per poll strobe choice except SEL_ALL
        for (int s = 0; s < 3; s++) begin
            apb(1'b1, REG_ADDR, 32'h40); apb(1'b1, REG_BUF, 32'h5a + s); apb(1'b1, REG_BUF + 12'h4, 32'ha5 - s);
            apb(1'b1, REG_CTRL, 32'h43 | 32'(s << 4));
            waitDone; `CHK("page status", 2'b01, rd[2:1])
            apb(1'b1, REG_STAT, 32'h6); apb(1'b1, REG_ADDR, 32'h41); apb(1'b1, REG_CTRL, 32'h1);
            waitDone; `CHK("page readback", 8'(165 - s), rd[15:8])
            apb(1'b1, REG_STAT, 32'h6);
            $display("test page %0d finished", s);
        end
        // one command write alone, then polled to the end of its period
        apb(1'b1, REG_SEQ, {9'h0, 15'h1555, 8'haa}); apb(1'b1, REG_CTRL, 32'h1037);
        waitDone; `CHK("command status", 2'b01, rd[2:1])
        apb(1'b1, REG_STAT, 32'h6); apb(1'b1, REG_ADDR, 32'h1555); apb(1'b1, REG_CTRL, 32'h1);
        waitDone; `CHK("command readback", 8'haa, rd[15:8])
        $display("test command finished");
        // command write then one page byte, standard limit
        apb(1'b1, REG_SEQ, {9'h0, 15'h2aaa, 8'h55}); apb(1'b1, REG_ADDR, 32'h80); apb(1'b1, REG_BUF, 32'h3c);
        apb(1'b1, REG_STAT, 32'h6); apb(1'b1, REG_CTRL, 32'h1005);
        waitDone; `CHK("protect status", 2'b01, rd[2:1])
        apb(1'b1, REG_STAT, 32'h6); apb(1'b1, REG_CTRL, 32'h1);
        waitDone; `CHK("protect readback", 8'h3c, rd[15:8])
        $display("test protect finished");
        // fast limit is shorter than the model's write period, so the poll gives up
        apb(1'b1, REG_STAT, 32'h6); apb(1'b1, REG_CTRL, 32'h100f);
        waitDone; `CHK("timeout status", 2'b10, rd[2:1])
        apb(1'b1, REG_STAT, 32'h6); apb(1'b0, REG_STAT, 32'h0); `CHK("status cleared", 32'h3c00, rd)
        // reset with the controller idle after the timeout clears the last byte and all flags
        arst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        arst_n <= 1'b1;
        apb(1'b0, REG_STAT, 32'h0); `CHK("stat after reset", 32'h0, rd)
        $display("test timeout finished");
        close_out;
    end
    // watchdog well beyond the six thousand or so cycles the tests need
    initial begin
        #400000;
        errTotal++;
        close_out;
    end
endmodule // eeprom_write_protect_and_status_bench
